// File: dcf_consts.svh
// Constants of the dual-clock buffer port logic: offsets, reset values, widths.
// Assumes inclusion by bare name from the package and the design module.
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define DCF_DATA_W        9
`define DCF_DEPTH         16384
`define DCF_OFF_W         14

// ------------------------------------------------------------
// Offset defaults chosen by the load strap
// ------------------------------------------------------------
`define DCF_OFF_DEF_PAR   14'h007F
`define DCF_OFF_DEF_SER   14'h03FF

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define DCF_ADDR_CTRL     8'h00
`define DCF_ADDR_STATUS   8'h04
`define DCF_ADDR_EMPTY_OFF 8'h08
`define DCF_ADDR_FULL_OFF 8'h0C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DCF_CTRL_SOFT_RST 0
`define DCF_ST_FALL_THROUGH_MODE       0
`define DCF_ST_SERIAL     1
`define DCF_ST_FULL_N     2
`define DCF_ST_IR_N       3
`define DCF_ST_EMPTY_N    4
`define DCF_ST_OR_N       5

`endif

// File: dcf_pkg.sv
// Types of the dual-clock buffer port logic.
// Assumes dcf_consts.svh is on the include path.
`include "dcf_consts.svh"

package dcf_pkg;

  // Write port pins as one carrier
  typedef struct packed {
    logic                   clk;    // Write clock, sampled on mclk
    logic                   en_n;   // Write enable, active low
    logic [`DCF_DATA_W-1:0] data;   // Input word
  } dcf_wr_port_t;

  // Read port pins as one carrier
  typedef struct packed {
    logic clk;                      // Read clock, sampled on mclk
    logic en_n;                     // Read enable, active low
  } dcf_rd_port_t;

  // Offset programming pins as one carrier
  typedef struct packed {
    logic load_n;                   // Offset load, also default strap
    logic serial_en_n;              // Serial enable
    logic serial_in;                // Mode strap at master reset, then serial data
  } dcf_prog_t;

endpackage

// File: dcf_fifo_port.sv
// Dual-clock buffer port logic: write and read sides, flags, offsets, bus slave.
// Assumes write and read clocks arrive as pins synchronous to mclk, edges found here.
//
// Contract
// - Write enable low, not full: store word
// - Write enable high: memory unchanged
// - Write enable ignored while full
// - Write-side flags update only on write edges
// - Read-side flags update only on read edges
// - Read enable low, not empty: load output
// - Read enable high: output register holds, except a fall-through fill of an empty output register
// - Standard mode: every word needs read enable
// - Empty deasserts two read edges after write
// - Full releases two write edges after read
// - Fall-through: first word shows on third edge
// - Output-ready high only on true read
// - Serial load shifts one bit per edge
// - Serial enable high keeps offset registers
// - Output enable low drives data bus
// - Load strap picks default offsets and method
// - Offset writes only by chosen method
// - Standard full after depth writes
// - Input-ready counts output register word too
// - Output-ready low with valid output word
// - Flags pass two or three stages
// - Words stored in sequential order
// - Mode strap picks standard or fall-through
// - Nine-bit data in and out
// - Master reset clears pointers and output
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ns
`include "dcf_consts.svh"

module dcf_fifo_port #(
  parameter int DEPTH = `DCF_DEPTH,
  parameter int AW    = $clog2(`DCF_DEPTH)
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  // Buffer resets, synchronous pins
  input  wire logic                    master_reset_n,
  input  wire logic                    partial_reset_n,
  // Write port
  input  wire dcf_pkg::dcf_wr_port_t   wr_port,
  // Read port
  input  wire dcf_pkg::dcf_rd_port_t   rd_port,
  input  wire logic                    output_enable_n,
  // Offset programming pins
  input  wire dcf_pkg::dcf_prog_t      prog,
  // Data output with its enable
  output logic [`DCF_DATA_W-1:0]       data_out,
  output logic                         data_out_oe,
  // Flags
  output logic                         full_flag_n,
  output logic                         input_ready_n,
  output logic                         empty_flag_n,
  output logic                         output_ready_n,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o
);

  // ------------------------------------------------------------
  // Pointer code conversions
  // ------------------------------------------------------------
  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b     = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [`DCF_DATA_W-1:0] mem [DEPTH];     // Storage array
  logic                   wclk_d_reg;      // Write clock last sample
  logic                   rclk_d_reg;      // Read clock last sample
  logic                   wrise;           // Write clock edge seen
  logic                   rrise;           // Read clock edge seen
  logic                   clr;             // Pointer and output clear
  logic                   soft_rst_reg;    // Software partial reset pulse
  logic                   fall_through_mode_reg;        // Fall-through mode selected
  logic                   serial_reg;      // Serial offset method selected
  logic [AW:0]            wptr_reg;        // Write pointer, binary
  logic [AW:0]            rptr_reg;        // Read pointer, binary
  logic [AW:0]            wgray_reg;       // Write pointer, gray
  logic [AW:0]            rgray_reg;       // Read pointer, gray
  logic [AW:0]            rg_s1_reg;       // Read pointer into write side, stage 1
  logic [AW:0]            rg_s2_reg;       // Read pointer into write side, stage 2
  logic [AW:0]            wg_s1_reg;       // Write pointer into read side, stage 1
  logic [AW:0]            wg_s2_reg;       // Write pointer into read side, stage 2
  logic [AW:0]            wcount;          // Words held as seen by write side
  logic                   full;            // No room left
  logic                   mem_has;         // Memory holds unread words
  logic                   wr_ok;           // Accepted write
  logic                   rd_ok;           // Word moves to output register
  logic                   out_valid_reg;   // Output holds a fall-through word
  logic [`DCF_DATA_W-1:0] dout_reg;        // Output register
  logic [`DCF_OFF_W-1:0]  empty_off_reg;   // Almost-empty offset
  logic [`DCF_OFF_W-1:0]  full_off_reg;    // Almost-full offset
  logic                   wb_hit;          // Bus request this cycle
  logic [31:0]            rd_data;         // Read mux

  // ------------------------------------------------------------
  // Edge detection and clears
  // ------------------------------------------------------------
  // Clock pins sampled; stopped clocks give no edges
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wclk_d_reg <= 1'b0;
      rclk_d_reg <= 1'b0;
    end
    else
    begin
      wclk_d_reg <= wr_port.clk;
      rclk_d_reg <= rd_port.clk;
    end
  end

  assign wrise = wr_port.clk & ~wclk_d_reg;
  assign rrise = rd_port.clk & ~rclk_d_reg;
  assign clr   = ~resetn | ~master_reset_n | ~partial_reset_n | soft_rst_reg;

  // ------------------------------------------------------------
  // Mode and method straps
  // ------------------------------------------------------------
  // Straps are caught while master reset is held low
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      fall_through_mode_reg   <= 1'b0;
      serial_reg <= 1'b0;
    end
    else if (!master_reset_n)
    begin
      fall_through_mode_reg   <= prog.serial_in;
      serial_reg <= prog.load_n;
    end
  end

  // ------------------------------------------------------------
  // Write side
  // ------------------------------------------------------------
  // Programming (load low) diverts write enable away from the memory
  assign wcount = wptr_reg - gray2bin(rg_s2_reg);
  assign full   = (wcount == (AW+1)'(DEPTH));
  assign wr_ok  = wrise & ~wr_port.en_n & ~full & prog.load_n;

  // Memory write, sequential addresses
  always_ff @(posedge mclk)
  begin
    if (wr_ok)
    begin
      mem[wptr_reg[AW-1:0]] <= wr_port.data;
    end
  end

  // Write pointer advances only on accepted writes
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      wptr_reg  <= '0;
      wgray_reg <= '0;
    end
    else if (wr_ok)
    begin
      wptr_reg  <= wptr_reg + 1'b1;
      wgray_reg <= bin2gray(wptr_reg + 1'b1);
    end
  end

  // Read pointer into write side, stepping on write edges only
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end
    else if (wrise)
    begin
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  // Full in standard mode, input-ready in fall-through mode
  assign full_flag_n   = fall_through_mode_reg | ~full;
  assign input_ready_n = fall_through_mode_reg & full;

  // ------------------------------------------------------------
  // Read side
  // ------------------------------------------------------------
  assign mem_has = (wg_s2_reg != rgray_reg);
  // Standard: request needed. Fall-through: fill an empty output register.
  assign rd_ok = rrise & mem_has &
                 (fall_through_mode_reg ? (~out_valid_reg | ~rd_port.en_n) : ~rd_port.en_n);

  // Write pointer into read side, stepping on read edges only
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end
    else if (rrise)
    begin
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end

  // Read pointer
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      rptr_reg  <= '0;
      rgray_reg <= '0;
    end
    else if (rd_ok)
    begin
      rptr_reg  <= rptr_reg + 1'b1;
      rgray_reg <= bin2gray(rptr_reg + 1'b1);
    end
  end

  // Output register; holds while no word is moved
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      dout_reg <= '0;
    end
    else if (rd_ok)
    begin
      dout_reg <= mem[rptr_reg[AW-1:0]];
    end
  end

  // Fall-through output validity, third stage of output-ready
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      out_valid_reg <= 1'b0;
    end
    else if (rd_ok)
    begin
      out_valid_reg <= 1'b1;
    end
    else if (rrise & ~rd_port.en_n)
    begin
      out_valid_reg <= 1'b0;
    end
  end

  // Empty in standard mode, output-ready in fall-through mode
  assign empty_flag_n   = ~fall_through_mode_reg & mem_has;
  assign output_ready_n = ~(fall_through_mode_reg & out_valid_reg);

  // Three-state control of the output bus
  assign data_out    = dout_reg;
  assign data_out_oe = ~output_enable_n;

  // ------------------------------------------------------------
  // Offset registers
  // ------------------------------------------------------------
  // Defaults at master reset; serial shift or bus write afterwards
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      empty_off_reg <= `DCF_OFF_DEF_PAR;
      full_off_reg  <= `DCF_OFF_DEF_PAR;
    end
    else if (!master_reset_n)
    begin
      empty_off_reg <= prog.load_n ? `DCF_OFF_DEF_SER : `DCF_OFF_DEF_PAR;
      full_off_reg  <= prog.load_n ? `DCF_OFF_DEF_SER : `DCF_OFF_DEF_PAR;
    end
    else if (serial_reg & wrise & ~prog.load_n & ~prog.serial_en_n)
    begin
      empty_off_reg <= {full_off_reg[0], empty_off_reg[`DCF_OFF_W-1:1]};
      full_off_reg  <= {prog.serial_in, full_off_reg[`DCF_OFF_W-1:1]};
    end
    else if (wb_hit & wb_we_i & ~serial_reg & wb_sel_i[0] & wb_sel_i[1])
    begin
      if (wb_adr_i == `DCF_ADDR_EMPTY_OFF)
      begin
        empty_off_reg <= wb_dat_i[`DCF_OFF_W-1:0];
      end
      else if (wb_adr_i == `DCF_ADDR_FULL_OFF)
      begin
        full_off_reg <= wb_dat_i[`DCF_OFF_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Software partial reset, one-cycle pulse
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      soft_rst_reg <= 1'b0;
    end
    else
    begin
      soft_rst_reg <= wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `DCF_ADDR_CTRL) &
                      wb_dat_i[`DCF_CTRL_SOFT_RST];
    end
  end

  // Read mux; unmapped addresses read zero; offsets always readable
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      `DCF_ADDR_STATUS:
      begin
        rd_data[`DCF_ST_FALL_THROUGH_MODE]    = fall_through_mode_reg;
        rd_data[`DCF_ST_SERIAL]  = serial_reg;
        rd_data[`DCF_ST_FULL_N]  = full_flag_n;
        rd_data[`DCF_ST_IR_N]    = input_ready_n;
        rd_data[`DCF_ST_EMPTY_N] = empty_flag_n;
        rd_data[`DCF_ST_OR_N]    = output_ready_n;
      end
      `DCF_ADDR_EMPTY_OFF: rd_data[`DCF_OFF_W-1:0] = empty_off_reg;
      `DCF_ADDR_FULL_OFF:  rd_data[`DCF_OFF_W-1:0] = full_off_reg;
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, data registered with it
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_data : 32'h0000_0000;
    end
  end

endmodule // dcf_fifo_port

// File: dcf_fifo_port_properties.sv
// Checker of the buffer port pins: flags, output word, output enable, bus answer.
// Assumes it is bound onto dcf_fifo_port and sees only that module's ports.
`timescale 1ns/1ns
`include "dcf_consts.svh"
module dcf_fifo_port_properties (
  // Clock and resets
  input wire logic                   mclk,
  input wire logic                   resetn,
  input wire logic                   master_reset_n,
  input wire logic                   partial_reset_n,
  // Far-side pins
  input wire dcf_pkg::dcf_wr_port_t  wr_port,
  input wire dcf_pkg::dcf_rd_port_t  rd_port,
  input wire logic                   output_enable_n,
  // Outputs
  input wire logic [`DCF_DATA_W-1:0] data_out,
  input wire logic                   data_out_oe,
  input wire logic                   full_flag_n,
  input wire logic                   input_ready_n,
  input wire logic                   empty_flag_n,
  input wire logic                   output_ready_n,
  // Bus
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic                   wb_ack_o
);
  logic wr_prev;   // Write clock pin one cycle ago
  logic rd_prev;   // Read clock pin one cycle ago
  logic wbw_reg;   // A bus write was pending last cycle
  logic clr_prev;  // A reset pin was low last cycle
  // Pin history; reset clears the clock and bus samples, sets clr_prev
  always_ff @(posedge mclk)
  begin
    wr_prev  <= resetn & wr_port.clk;
    rd_prev  <= resetn & rd_port.clk;
    wbw_reg  <= resetn & wb_cyc_i & wb_we_i;
    clr_prev <= !resetn | !master_reset_n | !partial_reset_n;
  end
  wire wr_rise = wr_port.clk & ~wr_prev;
  wire rd_rise = rd_port.clk & ~rd_prev;
  // Bus writes may pulse the soft reset; a reset pin clears at the edge it is seen
  wire bus_wr_mask = (wb_cyc_i & wb_we_i) | wbw_reg | clr_prev;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn || !master_reset_n || !partial_reset_n || bus_wr_mask);

  oe_follows_pin_a: assert property (data_out_oe == !output_enable_n)
    else $error("output enable differs from its pin");
  out_hold_a: assert property (!rd_rise |=> $stable(data_out))
    else $error("output word moved without a read edge");
  read_flags_idle_a: assert property (!rd_rise |=>
    $stable(empty_flag_n) && $stable(output_ready_n))
    else $error("read-side flag moved without a read edge");
  write_flags_idle_a: assert property (!wr_rise |=>
    $stable(full_flag_n) && $stable(input_ready_n))
    else $error("write-side flag moved without a write edge");
  ready_true_read_a: assert property (
    !output_ready_n && !(rd_rise && !rd_port.en_n) |=> !output_ready_n)
    else $error("output ready dropped without a true read");
  valid_word_held_a: assert property (!output_ready_n && rd_port.en_n |=> $stable(data_out))
    else $error("valid output word changed while read enable high");
  mode_flags_a: assert property (
    !(!full_flag_n && input_ready_n) && !(empty_flag_n && !output_ready_n) &&
    !(!full_flag_n && !output_ready_n) && !(input_ready_n && empty_flag_n))
    else $error("flags of both modes active together");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
endmodule // dcf_fifo_port_properties

bind dcf_fifo_port dcf_fifo_port_properties chk (.mclk, .resetn, .master_reset_n, .partial_reset_n,
  .wr_port, .rd_port, .output_enable_n, .data_out, .data_out_oe, .full_flag_n, .input_ready_n,
  .empty_flag_n, .output_ready_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o);

// File: dcf_far_end.sv
// Far-side writer and reader: one clock pulse per call on the write or read pin.
// Assumes calls just after a rising mclk edge; clock pins stand still between calls.
`timescale 1ns/1ns
`include "dcf_consts.svh"
module dcf_far_end (
  // System clock
  input wire logic              mclk,
  // Pins toward the buffer
  output dcf_pkg::dcf_wr_port_t wr_port,
  output dcf_pkg::dcf_rd_port_t rd_port
);
  // Idle pins: clocks low, enables off
  initial
  begin
    wr_port = '{1'b0, 1'b1, 9'h000};
    rd_port = 2'h1;
  end
  // Word and enable held through the rising edge, then the word is let go
  task automatic wr_edge(input logic en_n, input logic [`DCF_DATA_W-1:0] d);
    wr_port <= '{1'b1, en_n, d};
    @(posedge mclk);
    wr_port <= '{1'b0, 1'b1, ~d};
    @(posedge mclk);
  endtask
  // Read enable held through the rising edge
  task automatic rd_edge(input logic en_n);
    rd_port <= {1'b1, en_n};
    @(posedge mclk);
    rd_port <= 2'h1;
    @(posedge mclk);
  endtask
endmodule // dcf_far_end

// File: dual_clock_fifo_port_flags_test.sv
// Bench of the buffer port logic: both read modes, flags, offsets, bus.
// Assumes a 16-word depth; the clock pins come from dcf_far_end.
`timescale 1ns/1ns
`include "dcf_consts.svh"
module dual_clock_fifo_port_flags_test;
  logic                   mclk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   master_reset_n = 1'b0;
  logic                   partial_reset_n = 1'b1;
  logic                   output_enable_n = 1'b0;
  logic                   wb_cyc_i = 1'b0;
  logic                   wb_stb_i = 1'b0;
  logic                   wb_we_i = 1'b0;
  logic [7:0]             wb_adr_i = 8'h00;
  logic [3:0]             wb_sel_i = 4'hF;
  logic [31:0]            wb_dat_i = 32'h0000_0000;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o, data_out_oe, full_flag_n, input_ready_n;
  logic                   empty_flag_n, output_ready_n;
  logic [`DCF_DATA_W-1:0] data_out;
  dcf_pkg::dcf_wr_port_t  wr_port;
  dcf_pkg::dcf_rd_port_t  rd_port;
  dcf_pkg::dcf_prog_t     prog = 3'h2;
  int                     num_errors = 0;
  int                     check_count = 0;
  logic [15:0]            seed = 16'h73CC;
  logic [27:0]            sh;
  logic [31:0]            r;
  int                     q[$];
  int                     cap, last;

  always #5 mclk = ~mclk;
  dcf_far_end far (.mclk, .wr_port, .rd_port);
  dcf_fifo_port #(.DEPTH(16), .AW(4)) dut (.mclk, .resetn, .master_reset_n, .partial_reset_n,
    .wr_port, .rd_port, .output_enable_n, .prog, .data_out, .data_out_oe, .full_flag_n,
    .input_ready_n, .empty_flag_n, .output_ready_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Classic bus cycle, held until the answer
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      finish_test();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    check("register", r, exp);
  endtask
  // Write edge with a fresh word; the model keeps what the buffer may take
  task automatic put(input logic en);
    seed = lfsr(seed);
    output_enable_n <= seed[1];
    if (en && q.size() < cap)
      q.push_back(int'(seed[8:0]));
    far.wr_edge(!en, seed[8:0]);
    check("output enable", data_out_oe, !seed[1]);
  endtask
  task automatic mreset(input logic fall_through_mode, input logic load);
    prog <= '{load, 1'b1, fall_through_mode};
    master_reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    master_reset_n <= 1'b1;
    // Load high and serial enable off, so the memory takes writes
    prog <= 3'h6;
    q.delete();
    cap = fall_through_mode ? 17 : 16;
    @(posedge mclk);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    mreset(1'b0, 1'b0);
    rd_reg(8'h04, 32'h0000_0024);
    rd_reg(8'h0C, 32'h0000_007F);
    seed = lfsr(seed);
    wb(1'b1, 8'h08, {18'h0_0000, seed[13:0]});
    rd_reg(8'h08, {18'h0_0000, seed[13:0]});
    // Only one byte lane selected: the offset write is refused
    wb_sel_i <= 4'h1;
    wb(1'b1, 8'h0C, {18'h0_0000, 1'b1, seed[12:0]});
    wb_sel_i <= 4'hF;
    rd_reg(8'h0C, 32'h0000_007F);
    rd_reg(8'h10, 32'h0000_0000);
    put(1'b1);
    far.rd_edge(1'b1);
    check("empty", empty_flag_n, 0);
    far.rd_edge(1'b1);
    check("empty", empty_flag_n, 1);
    check("output", data_out, 0);
    for (int i = 0; i < 17; i++)
    begin
      put(i != 3);
      check("full", full_flag_n, q.size() < 16);
    end
    repeat (2) far.rd_edge(1'b1);
    while (q.size() > 0)
    begin
      far.rd_edge(1'b0);
      check("output", data_out, q.pop_front());
      check("empty", empty_flag_n, q.size() > 0);
      if (q.size() == 15)
      begin
        put(1'b0);
        check("full", full_flag_n, 0);
        put(1'b0);
        check("full", full_flag_n, 1);
      end
    end
    last = data_out;
    far.rd_edge(1'b0);
    check("output", data_out, last);
    // Software partial reset clears the output register
    wb(1'b1, 8'h00, 32'h0000_0001);
    check("output", data_out, 0);
    rd_reg(8'h04, 32'h0000_0024);
    mreset(1'b1, 1'b1);
    rd_reg(8'h04, 32'h0000_0027);
    wb(1'b1, 8'h08, 32'h0000_0011);
    rd_reg(8'h08, 32'h0000_03FF);
    for (int i = 0; i < 29; i++)
    begin
      seed = lfsr(seed);
      prog <= (i == 14) ? 3'h3 : {2'b00, seed[0]};
      sh = (i == 14) ? sh : {seed[0], sh[27:1]};
      far.wr_edge(1'b1, seed[8:0]);
    end
    prog <= 3'h6;
    rd_reg(8'h08, {18'h0_0000, sh[13:0]});
    rd_reg(8'h0C, {18'h0_0000, sh[27:14]});
    put(1'b1);
    repeat (2) far.rd_edge(1'b1);
    check("ready", output_ready_n, 1);
    far.rd_edge(1'b1);
    check("ready", output_ready_n, 0);
    check("output", data_out, q[0]);
    for (int i = 1; i < 18; i++)
    begin
      put(1'b1);
      check("input ready", input_ready_n, q.size() == 17);
    end
    repeat (2) far.rd_edge(1'b1);
    check("output", data_out, q[0]);
    while (q.size() > 0)
    begin
      last = q.pop_front();
      far.rd_edge(1'b0);
      check("output", data_out, (q.size() > 0) ? q[0] : last);
      check("ready", output_ready_n, q.size() == 0);
    end
    far.rd_edge(1'b0);
    check("output", data_out, last);
    partial_reset_n <= 1'b0;
    @(posedge mclk);
    partial_reset_n <= 1'b1;
    @(posedge mclk);
    check("output", data_out, 0);
    rd_reg(8'h04, 32'h0000_0027);
    finish_test();
  end
endmodule // dual_clock_fifo_port_flags_test
